/* File: hdl/pbc_pkg.sv */
// package for the peripheral bus controller: cycle codes, timing counts, carriers
// assumes one 20 MHz clock shared with the processor local bus
package pbc_pkg;

	// ****************************************************************
	// cycle definition codes {mem_io, data_ctl, write_rd}
	// ****************************************************************
	localparam logic [2:0] CYC_INTERRUPT_ACK_N    = 3'h0;
	localparam logic [2:0] CYC_SPECIAL = 3'h1;
	localparam logic [2:0] CYC_IO_RD   = 3'h2;
	localparam logic [2:0] CYC_IO_WR   = 3'h3;
	localparam logic [2:0] CYC_CODE_RD = 3'h4;
	localparam logic [2:0] CYC_RSVD    = 3'h5;
	localparam logic [2:0] CYC_MEM_RD  = 3'h6;
	localparam logic [2:0] CYC_MEM_WR  = 3'h7;

	// ****************************************************************
	// timing counts
	// ****************************************************************
	localparam int CLK_MHZ          = 20;
	localparam int IO_WAIT_NS       = 150;
	localparam int IO_WAIT_CYC      = (IO_WAIT_NS * CLK_MHZ + 999) / 1000;
	localparam int TURNAROUND_GAP_NS         = 100;
	localparam int TURNAROUND_GAP_CYC        = (TURNAROUND_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int INTERRUPT_ACK_N_PULSE_NS    = 100;
	localparam int INTERRUPT_ACK_N_PULSE_CYC   = (INTERRUPT_ACK_N_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int INTERRUPT_ACK_N_PULSES      = 2;
	localparam int ROM_WAIT_NS      = 150;
	localparam int ROM_WAIT_CYC     = (ROM_WAIT_NS * CLK_MHZ + 999) / 1000;

	// ****************************************************************
	// reset values and address map
	// ****************************************************************
	localparam logic [3:0]  SWAP_OFF      = 4'hf;
	localparam logic [31:0] ROM_BASE      = 32'hffff0000;
	localparam logic [31:0] ROM_MASK      = 32'hffff0000;
	localparam logic [31:0] IO_WIN_BASE   = 32'h000f0000;
	localparam logic [31:0] IO_WIN_MASK   = 32'hffff0000;
	localparam logic [3:0]  BE_NONE       = 4'hf;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic       mem_io;
		logic       data_ctl;
		logic       write_rd;
	} pbc_status_t;

	typedef struct packed {
		logic       io_read_cmd_n;
		logic       io_write_cmd_n;
		logic       io_cycle_qualifier_n;
		logic       rom_read_cmd_n;
		logic       interrupt_ack_n;
	} pbc_cmd_t;

	typedef struct packed {
		logic       swap16_buffer_enable_n;
		logic       swap8_upper_high_enable_n;
		logic       swap8_upper_low_enable_n;
		logic       swap8_high_enable_n;
	} pbc_swap_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_CMD   = 3'b001,
		ST_DONE  = 3'b011,
		ST_GAP   = 3'b010,
		ST_IGAP  = 3'b110
	} pbc_state_t;

endpackage

/* File: hdl/pbc_peripheral_bus_control.sv */
// peripheral bus controller between the processor local bus and slave i/o devices
// assumes status, address and byte lanes synchronous to clk; the processor holds
// them steady until ready; peripherals decode their own chip selects
//
// How it works
// - decode write/read, memory/io, data/control status and drive matching command
// - i/o read status asserts io read command to select driving peripheral
// - i/o write status asserts io write command so peripheral takes data
// - qualifier goes low for valid i/o cycle; read/write command follows it
// - memory or code read in boot rom region asserts rom read command
// - turnaround gap spaces successive peripheral accesses against contention
// - interrupt acknowledge cycle issues a sequence of acknowledge pulses
// - four byte-lane buffers, each enabled by its own byte enable line
// - 32-bit interface keeps all four swap buffer enables high always
// - empty or non-contiguous byte enable patterns never occur; treated don't-care
// - a 64 KB memory window aliases the whole i/o space
// - status sampled only while address strobe is asserted
// - ready output marks completion of the current bus cycle
// - wait states inserted by holding ready deasserted
module pbc_peripheral_bus_control #(
	parameter int IO_WAITS   = pbc_pkg::IO_WAIT_CYC,
	parameter int ROM_WAITS  = pbc_pkg::ROM_WAIT_CYC,
	parameter int GAP_CYCLES = pbc_pkg::TURNAROUND_GAP_CYC,
	parameter int ACK_WIDTH  = pbc_pkg::INTERRUPT_ACK_N_PULSE_CYC,
	parameter int ACK_PULSES = pbc_pkg::INTERRUPT_ACK_N_PULSES
) (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                address_strobe_n,
	input  wire pbc_pkg::pbc_status_t status,
	input  wire logic [31:0]         address,
	input  wire logic [3:0]          byte_lane_enables_n,
	output logic                     ready_n,
	output pbc_pkg::pbc_cmd_t        cmd,
	output logic                     turnaround_gap,
	output logic [3:0]               lane_buffer_enable_n,
	output logic                     lane_write_dir,
	output pbc_pkg::pbc_swap_t       swap
);

	// ****************************************************************
	// cycle decode
	// ****************************************************************
	pbc_pkg::pbc_state_t state_q;
	logic [2:0]          cyc_q;
	logic                rom_hit_q;
	logic                io_alias_q;
	logic [7:0]          cnt_q;
	logic [3:0]          pulses_q;
	logic                ack_phase_q;

	// window match used for rom region and i/o alias
	function automatic logic in_window(input logic [31:0] a, input logic [31:0] base,
		input logic [31:0] mask);
		in_window = ((a & mask) == base);
	endfunction

	logic       strobe;
	logic [2:0] cyc_now;
	assign strobe  = !address_strobe_n && (state_q == pbc_pkg::ST_IDLE);
	assign cyc_now = {status.mem_io, status.data_ctl, status.write_rd};

	always_ff @(posedge clk) begin
		if (rst) begin
			cyc_q      <= pbc_pkg::CYC_SPECIAL;
			rom_hit_q  <= 1'b0;
			io_alias_q <= 1'b0;
		end else if (strobe) begin
			cyc_q      <= cyc_now;
			rom_hit_q  <= in_window(address, pbc_pkg::ROM_BASE, pbc_pkg::ROM_MASK);
			io_alias_q <= in_window(address, pbc_pkg::IO_WIN_BASE, pbc_pkg::IO_WIN_MASK);
		end
	end

	logic is_io_rd;
	logic is_io_wr;
	logic is_interrupt_ack_n;
	logic is_rom;
	// alias turns memory reads/writes in the window into i/o commands
	assign is_io_rd = (cyc_q == pbc_pkg::CYC_IO_RD) || (io_alias_q && cyc_q == pbc_pkg::CYC_MEM_RD);
	assign is_io_wr = (cyc_q == pbc_pkg::CYC_IO_WR) || (io_alias_q && cyc_q == pbc_pkg::CYC_MEM_WR);
	assign is_interrupt_ack_n  = (cyc_q == pbc_pkg::CYC_INTERRUPT_ACK_N);
	assign is_rom   = rom_hit_q && (cyc_q == pbc_pkg::CYC_MEM_RD || cyc_q == pbc_pkg::CYC_CODE_RD);

	// ****************************************************************
	// sequencer
	// ****************************************************************
	logic [7:0] waits;
	always_comb begin
		waits = 8'h01;
		if (is_io_rd || is_io_wr) begin
			waits = 8'(IO_WAITS);
		end else if (is_rom) begin
			waits = 8'(ROM_WAITS);
		end else if (is_interrupt_ack_n) begin
			waits = 8'(ACK_WIDTH);
		end
	end

	// state walk: idle, command with waits, done (ready), gap
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q     <= pbc_pkg::ST_IDLE;
			cnt_q       <= 8'h00;
			pulses_q    <= 4'h0;
			ack_phase_q <= 1'b0;
		end else begin
			unique case (state_q)
				pbc_pkg::ST_IDLE: begin
					if (strobe) begin
						state_q     <= pbc_pkg::ST_CMD;
						cnt_q       <= 8'h00;
						pulses_q    <= 4'h0;
						ack_phase_q <= 1'b1;
					end
				end
				pbc_pkg::ST_CMD: begin
					// hold off ready while counting waits
					if (is_interrupt_ack_n) begin
						// pulse train, low then high gap, per pulse
						if (cnt_q + 8'h01 >= waits) begin
							cnt_q       <= 8'h00;
							ack_phase_q <= !ack_phase_q;
							if (!ack_phase_q) begin
								pulses_q <= pulses_q + 4'h1;
							end
							if (ack_phase_q && (pulses_q + 4'h1 >= 4'(ACK_PULSES))) begin
								state_q <= pbc_pkg::ST_DONE;
							end
						end else begin
							cnt_q <= cnt_q + 8'h01;
						end
					end else if (cnt_q + 8'h01 >= waits) begin
						state_q <= pbc_pkg::ST_DONE;
					end else begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				pbc_pkg::ST_DONE: begin
					cnt_q <= 8'h00;
					// peripheral access is followed by a recovery gap
					if (is_io_rd || is_io_wr || is_interrupt_ack_n || is_rom) begin
						state_q <= pbc_pkg::ST_GAP;
					end else begin
						state_q <= pbc_pkg::ST_IGAP;
					end
				end
				pbc_pkg::ST_GAP: begin
					if (cnt_q + 8'h01 >= 8'(GAP_CYCLES)) begin
						state_q <= pbc_pkg::ST_IDLE;
					end else begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				pbc_pkg::ST_IGAP: begin
					state_q <= pbc_pkg::ST_IDLE;
				end
				default: begin
					state_q <= pbc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// registered outputs
	// ****************************************************************
	logic in_cmd;
	assign in_cmd = (state_q == pbc_pkg::ST_CMD);

	logic io_start;
	// qualifier leads the command, aliased memory cycles included
	// so that a decoder never sees a read or write strobe before its qualifier
	assign io_start = strobe && ((cyc_now == pbc_pkg::CYC_IO_RD) || (cyc_now == pbc_pkg::CYC_IO_WR) ||
		(in_window(address, pbc_pkg::IO_WIN_BASE, pbc_pkg::IO_WIN_MASK) &&
		(cyc_now == pbc_pkg::CYC_MEM_RD || cyc_now == pbc_pkg::CYC_MEM_WR)));

	// ready low exactly one cycle to end the bus cycle
	// the acknowledge train ends on the last edge of its final active phase
	always_ff @(posedge clk) begin
		if (rst) begin
			ready_n <= 1'b1;
		end else begin
			ready_n <= !(in_cmd && !is_interrupt_ack_n && (cnt_q + 8'h01 >= waits)) &&
				!(in_cmd && is_interrupt_ack_n && ack_phase_q && (cnt_q + 8'h01 >= waits) &&
				(pulses_q + 4'h1 >= 4'(ACK_PULSES)));
		end
	end

	// commands held while in command state, dropped with ready
	always_ff @(posedge clk) begin
		if (rst) begin
			cmd <= '1;
		end else begin
			cmd.io_cycle_qualifier_n <= !(io_start ||
				(in_cmd && (is_io_rd || is_io_wr) && cnt_q + 8'h01 < waits));
			cmd.io_read_cmd_n  <= !(in_cmd && is_io_rd && cnt_q + 8'h01 < waits);
			cmd.io_write_cmd_n <= !(in_cmd && is_io_wr && cnt_q + 8'h01 < waits);
			// rom read held during rom cycle
			cmd.rom_read_cmd_n <= !(in_cmd && is_rom && cnt_q + 8'h01 < waits);
			// acknowledge low on the active phase of each pulse
			// registered from the phase that follows this edge, so each pulse is full width
			cmd.interrupt_ack_n <= !((strobe && cyc_now == pbc_pkg::CYC_INTERRUPT_ACK_N) ||
				(in_cmd && is_interrupt_ack_n && (ack_phase_q ^ (cnt_q + 8'h01 >= waits))));
		end
	end

	// recovery signal high through the gap
	always_ff @(posedge clk) begin
		if (rst) begin
			turnaround_gap <= 1'b0;
		end else begin
			turnaround_gap <= (state_q == pbc_pkg::ST_DONE && (is_io_rd || is_io_wr || is_interrupt_ack_n || is_rom)) ||
				(state_q == pbc_pkg::ST_GAP && cnt_q + 8'h01 < 8'(GAP_CYCLES));
		end
	end

	// each lane buffer follows its own byte enable during every bus cycle, data or control
	always_ff @(posedge clk) begin
		if (rst) begin
			lane_buffer_enable_n <= pbc_pkg::BE_NONE;
			lane_write_dir       <= 1'b0;
		end else begin
			if (strobe || in_cmd) begin
				lane_buffer_enable_n <= byte_lane_enables_n;
			end else begin
				lane_buffer_enable_n <= pbc_pkg::BE_NONE;
			end
			if (strobe) begin
				lane_write_dir <= status.write_rd;
			end
		end
	end

	// 32-to-32 interface never swaps, whatever the pattern
	always_ff @(posedge clk) begin
		if (rst) begin
			swap <= pbc_pkg::SWAP_OFF;
		end else begin
			swap <= pbc_pkg::SWAP_OFF;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	sequence s_io_start;
		!address_strobe_n && state_q == pbc_pkg::ST_IDLE && cyc_now == pbc_pkg::CYC_IO_RD &&
			!in_window(address, pbc_pkg::IO_WIN_BASE, pbc_pkg::IO_WIN_MASK);
	endsequence

	AST_IORD: assert property (@(posedge clk) disable iff (rst)
		s_io_start |=> ##1 !cmd.io_read_cmd_n)
		else $error("io read command missing");
	AST_QUAL: assert property (@(posedge clk) disable iff (rst)
		!cmd.io_read_cmd_n || !cmd.io_write_cmd_n |-> !cmd.io_cycle_qualifier_n)
		else $error("command without qualifier");
	AST_EXCL: assert property (@(posedge clk) disable iff (rst)
		!(!cmd.io_read_cmd_n && !cmd.io_write_cmd_n))
		else $error("read and write together");
	AST_DROP: assert property (@(posedge clk) disable iff (rst)
		!ready_n |-> cmd.io_read_cmd_n && cmd.io_write_cmd_n && cmd.rom_read_cmd_n)
		else $error("command still low at ready");
	AST_RDYEND: assert property (@(posedge clk) disable iff (rst)
		!ready_n |=> ready_n ##1 turnaround_gap || ready_n)
		else $error("ready longer than one cycle");
	AST_WAIT: assert property (@(posedge clk) disable iff (rst)
		s_io_start |=> ready_n [*2])
		else $error("ready too early");
	AST_GAP: assert property (@(posedge clk) disable iff (rst)
		$fell(cmd.io_read_cmd_n) |-> ##[1:40] turnaround_gap)
		else $error("no recovery gap");
	AST_SWAP: assert property (@(posedge clk) disable iff (rst)
		swap == pbc_pkg::SWAP_OFF)
		else $error("swap enable asserted");
	AST_LANE: assert property (@(posedge clk) disable iff (rst)
		state_q == pbc_pkg::ST_IDLE && address_strobe_n |=> lane_buffer_enable_n == pbc_pkg::BE_NONE)
		else $error("lane buffer on while idle");
	AST_SAMP: assert property (@(posedge clk) disable iff (rst)
		state_q == pbc_pkg::ST_IDLE && address_strobe_n |=> state_q == pbc_pkg::ST_IDLE)
		else $error("cycle started without strobe");

	sequence s_interrupt_ack_n_start;
		!address_strobe_n && state_q == pbc_pkg::ST_IDLE && cyc_now == pbc_pkg::CYC_INTERRUPT_ACK_N;
	endsequence

	AST_ACKRDY: assert property (@(posedge clk) disable iff (rst)
		s_interrupt_ack_n_start |-> ##[1:40] !ready_n)
		else $error("acknowledge train without ready");
	AST_ACKSEP: assert property (@(posedge clk) disable iff (rst)
		!cmd.interrupt_ack_n |-> cmd.io_read_cmd_n && cmd.io_write_cmd_n)
		else $error("acknowledge with i/o command");
	AST_ROMQ: assert property (@(posedge clk) disable iff (rst)
		!cmd.rom_read_cmd_n |-> cmd.io_cycle_qualifier_n)
		else $error("rom read inside an i/o cycle");
	AST_GAPQ: assert property (@(posedge clk) disable iff (rst)
		turnaround_gap |-> cmd == '1)
		else $error("command during recovery gap");
	AST_QFIRST: assert property (@(posedge clk) disable iff (rst)
		$fell(cmd.io_read_cmd_n) || $fell(cmd.io_write_cmd_n) |-> $past(cmd.io_cycle_qualifier_n) == 1'b0)
		else $error("command before qualifier");
	AST_LANEON: assert property (@(posedge clk) disable iff (rst)
		in_cmd |-> lane_buffer_enable_n != pbc_pkg::BE_NONE)
		else $error("no lane buffer during cycle");

endmodule

/* File: testbench/pbc_cpu_model.sv */
// processor local bus model: issues cycles, holds them until ready
// assumes calls start just after a rising edge of clk
module pbc_cpu_model (
	input  wire logic                 clk,
	output logic                      address_strobe_n,
	output pbc_pkg::pbc_status_t      status,
	output logic [31:0]               address,
	output logic [3:0]                byte_lane_enables_n,
	input  wire logic                 ready_n,
	input  wire pbc_pkg::pbc_cmd_t    cmd,
	input  wire logic [3:0]           lane_buffer_enable_n,
	input  wire logic                 lane_write_dir,
	input  wire logic                 turnaround_gap,
	input  wire pbc_pkg::pbc_swap_t   swap
);
	timeunit 1ns;
	timeprecision 100ps;
	int         cyc, n_rd, n_wr, n_q, n_rom, n_ack, n_fall, n_gap;
	logic       lane_bad, swap_bad, dir_w, ack_q;
	logic [4:0] cmd_end;

	// idle bus at time zero
	initial begin
		address_strobe_n = 1'b1;
		status = '0;
		address = '0;
		byte_lane_enables_n = 4'hf;
	end

	// one cycle: strobe, hold, count what comes back, watch the gap
	task automatic bus_cycle(input logic [2:0] st, input logic [31:0] a, input logic [3:0] be, input int watch);
		{n_rd, n_wr, n_q, n_rom, n_ack, n_fall, n_gap} = '0;
		{lane_bad, swap_bad, ack_q} = 3'h1;
		address_strobe_n = 1'b0;
		status = st;
		address = a;
		byte_lane_enables_n = be;
		@(posedge clk);
		#1 address_strobe_n = 1'b1;
		dir_w = lane_write_dir;
		for (cyc = 1; cyc < 64 && ready_n !== 1'b0; cyc++) begin
			n_rd += int'(cmd.io_read_cmd_n === 1'b0);
			n_wr += int'(cmd.io_write_cmd_n === 1'b0);
			n_q += int'(cmd.io_cycle_qualifier_n === 1'b0);
			n_rom += int'(cmd.rom_read_cmd_n === 1'b0);
			n_ack += int'(cmd.interrupt_ack_n === 1'b0);
			n_fall += int'(ack_q === 1'b1 && cmd.interrupt_ack_n === 1'b0);
			ack_q = cmd.interrupt_ack_n;
			lane_bad |= (lane_buffer_enable_n !== be);
			swap_bad |= (swap !== 4'hf);
			@(posedge clk);
			#1;
		end
		cmd_end = cmd;
		// released lines carry no stale value
		status = ~st;
		address = ~a;
		byte_lane_enables_n = ~be;
		repeat (watch) begin
			@(posedge clk);
			#1 n_gap += int'(turnaround_gap === 1'b1);
		end
	endtask

	// strobe in the recovery gap; counts any ready that follows
	task automatic stray(output int n_ready);
		n_ready = 0;
		@(posedge clk);
		#1 address_strobe_n = 1'b0;
		status = pbc_pkg::CYC_IO_RD;
		@(posedge clk);
		#1 address_strobe_n = 1'b1;
		repeat (10) begin
			n_ready += int'(ready_n === 1'b0);
			@(posedge clk);
			#1;
		end
	endtask
endmodule

/* File: testbench/pbc_peripheral_bus_control_bench.sv */
// self-checking bench for the peripheral bus controller
// assumes the processor model drives the local bus side
module pbc_peripheral_bus_control_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int          IOW = 3, ROMW = 3, GAP = 2, AW = 2, AP = 2;
	localparam logic [39:0] BE_OK = 40'h08ce19d3b7;
	logic                   clk, rst, strobe_n, ready_n, gap, dir;
	pbc_pkg::pbc_status_t   st;
	logic [31:0]            addr;
	logic [3:0]             be_n, lanes_n;
	pbc_pkg::pbc_cmd_t      cmd;
	pbc_pkg::pbc_swap_t     swap;
	int                     n_errors, n_compared, ticks, n;

	pbc_peripheral_bus_control #(.IO_WAITS(IOW), .ROM_WAITS(ROMW), .GAP_CYCLES(GAP), .ACK_WIDTH(AW),
		.ACK_PULSES(AP)) u_dut (.clk(clk), .rst(rst), .address_strobe_n(strobe_n), .status(st),
		.address(addr), .byte_lane_enables_n(be_n), .ready_n(ready_n), .cmd(cmd), .turnaround_gap(gap),
		.lane_buffer_enable_n(lanes_n), .lane_write_dir(dir), .swap(swap));
	pbc_cpu_model u_cpu (.clk(clk), .address_strobe_n(strobe_n), .status(st), .address(addr),
		.byte_lane_enables_n(be_n), .ready_n(ready_n), .cmd(cmd), .lane_buffer_enable_n(lanes_n),
		.lane_write_dir(dir), .turnaround_gap(gap), .swap(swap));

	// clock and hang limit
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		ticks++;
		if (ticks == 5000) begin
			n_errors++;
			complete_run();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		if (n_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic idle_state();
		check(cmd, 5'h1f);
		check(gap, 1'b0);
		check(lanes_n, 4'hf);
		check(swap, 4'hf);
	endtask

	task automatic io_read();
		u_cpu.bus_cycle(pbc_pkg::CYC_IO_RD, 32'h00000040, 4'h0, 8);
		check(u_cpu.cyc, IOW + 1);
		check(u_cpu.n_rd, IOW - 1);
		check(u_cpu.n_wr + u_cpu.n_rom, 0);
		check(u_cpu.n_q, IOW);
		check(u_cpu.cmd_end, 5'h1f);
		check(u_cpu.n_gap, GAP);
		check({u_cpu.lane_bad, u_cpu.dir_w}, 2'h0);
	endtask

	task automatic io_write();
		u_cpu.bus_cycle(pbc_pkg::CYC_IO_WR, 32'h00000044, 4'hc, 8);
		check(u_cpu.n_wr, IOW - 1);
		check(u_cpu.n_rd, 0);
		check(u_cpu.n_q, IOW);
		check({u_cpu.lane_bad, u_cpu.dir_w}, 2'h1);
		check(u_cpu.n_gap, GAP);
	endtask

	task automatic rom_read();
		for (int i = 0; i < 2; i++) begin
			u_cpu.bus_cycle(i ? pbc_pkg::CYC_MEM_RD : pbc_pkg::CYC_CODE_RD, 32'hffff0010, 4'h0, 8);
			check(u_cpu.n_rom, ROMW - 1);
			check(u_cpu.cyc, ROMW + 1);
			check(u_cpu.n_q + u_cpu.n_rd, 0);
		end
	endtask

	task automatic io_alias();
		u_cpu.bus_cycle(pbc_pkg::CYC_MEM_RD, 32'h000f0044, 4'h0, 8);
		check(u_cpu.n_rd, IOW - 1);
		check(u_cpu.n_q, IOW);
		u_cpu.bus_cycle(pbc_pkg::CYC_MEM_WR, 32'h000f0048, 4'h0, 8);
		check(u_cpu.n_wr, IOW - 1);
	endtask

	task automatic int_ack();
		u_cpu.bus_cycle(pbc_pkg::CYC_INTERRUPT_ACK_N, 32'h00000000, 4'he, 8);
		check(u_cpu.n_fall, AP);
		check(u_cpu.n_ack, AP * AW);
		check(u_cpu.cmd_end, 5'h1f);
	endtask

	task automatic lane_table();
		for (int i = 0; i < 10; i++) begin
			u_cpu.bus_cycle(pbc_pkg::CYC_MEM_WR, 32'h00001000, BE_OK[i*4 +: 4], 8);
			check(u_cpu.cyc, 2);
			check(u_cpu.n_rd + u_cpu.n_wr + u_cpu.n_rom + u_cpu.n_ack, 0);
			check(u_cpu.lane_bad, 1'b0);
			check(u_cpu.swap_bad, 1'b0);
		end
		u_cpu.bus_cycle(pbc_pkg::CYC_SPECIAL, 32'h00000000, 4'h0, 8);
		check(u_cpu.cyc, 2);
	endtask

	task automatic gap_refusal();
		u_cpu.bus_cycle(pbc_pkg::CYC_IO_RD, 32'h00000048, 4'h0, 0);
		u_cpu.stray(n);
		check(n, 0);
	endtask

	// main sequence
	initial begin
		{n_errors, n_compared, ticks} = '0;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		idle_state();
		io_read();
		io_write();
		rom_read();
		io_alias();
		int_ack();
		lane_table();
		gap_refusal();
		idle_state();
		complete_run();
	end
endmodule
